/* File: include/atf_pkg.sv */
// Shared constants for the task file and identify block.
package atf_pkg;
   // Task file register offsets on the plain register port.
   localparam logic [4:0] ATF_DATA      = 5'h00;
   localparam logic [4:0] ATF_ERROR     = 5'h01; // read; feature on write
   localparam logic [4:0] ATF_SECCNT    = 5'h02;
   localparam logic [4:0] ATF_SECNUM    = 5'h03;
   localparam logic [4:0] ATF_CYLLO     = 5'h04;
   localparam logic [4:0] ATF_CYLHI     = 5'h05;
   localparam logic [4:0] ATF_DRVHEAD   = 5'h06;
   localparam logic [4:0] ATF_STATUS    = 5'h07; // read; command on write
   localparam logic [4:0] ATF_ALTSTAT   = 5'h0e; // read; device control on write
   localparam logic [4:0] ATF_DRVADDR   = 5'h0f;
   localparam logic [4:0] ATF_CFG_OPT   = 5'h10;
   localparam logic [4:0] ATF_CFG_STAT  = 5'h11;
   localparam logic [4:0] ATF_PIN_REPL  = 5'h12;
   localparam logic [4:0] ATF_SOCK_COPY = 5'h13;
   localparam logic [4:0] ATF_MODE      = 5'h18; // own: mode, byte select
   localparam logic [4:0] ATF_DEV_EVT   = 5'h19;

   // Status bits.
   localparam int ATF_ST_BSY = 7;
   localparam int ATF_ST_RDY = 6;
   localparam int ATF_ST_DRQ = 3;
   localparam int ATF_ST_ERR = 0;
   localparam logic [7:0] ATF_STATUS_RST = 8'h50;

   // Device control and drive/head fields.
   localparam int ATF_DC_NIEN = 1;
   localparam int ATF_DC_SRST = 2;
   localparam int ATF_DH_LBA  = 6;
   // Configuration option fields.
   localparam int ATF_COR_SRESET = 7;
   localparam int ATF_COR_IDX_HI = 1;
   // Pin replacement interrupt bit.
   localparam int ATF_PRR_IREQ = 1;

   // Commands.
   localparam logic [7:0] ATF_CMD_IDENT  = 8'hec;
   localparam logic [7:0] ATF_CMD_DIAG   = 8'h90;
   localparam logic [7:0] ATF_CMD_SENSE  = 8'h03;
   localparam logic [7:0] ATF_CMD_SETFT  = 8'hef;
   localparam logic [7:0] ATF_FT_8BIT_ON = 8'h01;
   localparam logic [7:0] ATF_FT_8BIT_OF = 8'h81;
   localparam logic [7:0] ATF_DIAG_OK    = 8'h01;

   // Identify content.
   localparam logic [15:0] ATF_ID_W0_REM = 16'h848a;
   localparam logic [15:0] ATF_ID_W0_FIX = 16'h044a;
   localparam logic [15:0] ATF_ID_W22    = 16'h0004;
   localparam logic [15:0] ATF_ID_W47    = 16'h8001;
   localparam logic [15:0] ATF_ID_W49    = 16'h0b00;
   localparam logic [15:0] ATF_ID_W51    = 16'h0200;
   localparam logic [15:0] ATF_ID_W53    = 16'h0007;
   localparam logic [15:0] ATF_ID_W59    = 16'h0101;
   localparam logic [15:0] ATF_ID_W63    = 16'h0007;
   localparam logic [15:0] ATF_ID_W64    = 16'h0003;
   localparam logic [15:0] ATF_ID_W65_68 = 16'h0078;
   localparam logic [15:0] ATF_ID_W80    = 16'h0070;
   localparam logic [15:0] ATF_ID_W88    = 16'h003f;
   localparam logic [15:0] ATF_ID_TEXT   = 16'h2020; // arbitrary, blank ASCII
   localparam int          ATF_ID_WORDS  = 256;

   // Index mapping encodings.
   typedef enum logic [1:0] {
      ATF_MAP_MEM  = 2'b00,
      ATF_MAP_CONT = 2'b01,
      ATF_MAP_PRI  = 2'b10,
      ATF_MAP_SEC  = 2'b11
   } atf_map_t;

   typedef enum logic [1:0] {
      ATF_IDLE  = 2'b00,
      ATF_IDENT = 2'b01
   } atf_state_t;
endpackage : atf_pkg

/* File: rtl/atf_regs.sv */
// Task file, configuration registers and identify block of a flash ATA card.
`timescale 1ns/100ps
// Overview of operation
// - Word 0: removable 848A, fixed 044A.
// - Words 7-8 capacity, high half first.
// - Word 22 reads 0004.
// - Word 47 8001, word 59 block one.
// - Word 49 reads 0B00.
// - Word 53 reads 0007.
// - Words 57-58 capacity, low half first.
// - Word 63 reads 0007.
// - Word 64 reads 0003.
// - Words 65-68 each read 0078.
// - Word 88 reads 003F.
// - Configuration registers hidden in IDE mode.
// - Option register: soft reset, four mappings.
// - Pin replacement shows interrupt in I/O.
// - Data register: 16-bit, word or byte.
// - Error valid when idle; diag, sense codes.
// - LBA bit assembles 28-bit block address.
// - Status read clears interrupt; alternate not.
// - Device control: interrupt gate, soft reset.
// - Identify uses sector read data-in protocol.
// - IDE data word wide until set-features.
module atf_regs #(
   parameter logic [15:0] CYLS  = 16'h0400, // default cylinders
   parameter logic [15:0] HEADS = 16'h0010, // default heads
   parameter logic [15:0] SPT   = 16'h0020, // default sectors per track
   parameter logic [31:0] TOTAL = 32'h0008_0000 // total sectors
) (
   input  wire logic        sys_clk,   // 250 MHz clock
   input  wire logic        rstn,      // synchronous reset, active low
   input  wire logic        ide_mode,  // 1 = True IDE (fixed), 0 = PC Card
   input  wire logic [4:0]  addr,      // register address
   input  wire logic [15:0] wdata,     // write data
   input  wire logic        wr,        // write strobe
   input  wire logic        rd,        // read strobe
   output logic      [15:0] rdata,     // read data, cycle after rd
   output logic             irq,       // interrupt request, active high
   output logic      [7:0]  cmd,       // last command written
   output logic             cmd_stb,   // one-cycle command pulse
   output logic      [27:0] lba,       // assembled block address
   output logic      [8:0]  xfer_cnt,  // sectors to move, 1..256
   output logic             soft_rst,  // one-cycle soft reset pulse
   output atf_pkg::atf_map_t map_mode  // selected mapping
);
   import atf_pkg::*;

   logic [7:0]  feature, seccnt, secnum, cyllo, cylhi, drvhead, status, err;
   logic [7:0]  dev_ctl, cfg_opt, cfg_stat, sock_copy;
   logic [15:0] data_buf;
   logic        byte_mode, byte_hi, irq_pend;
   logic [7:0]  id_idx;
   atf_state_t  state;

   // Identify content: fixed words plus card dependent geometry.
   function automatic logic [15:0] id_word(input logic [7:0] w, input logic fixed);
      case (w)
         8'd0:    id_word = fixed ? ATF_ID_W0_FIX : ATF_ID_W0_REM;
         8'd1,
         8'd54:   id_word = CYLS;
         8'd3,
         8'd55:   id_word = HEADS;
         8'd6,
         8'd56:   id_word = SPT;
         8'd7:    id_word = TOTAL[31:16];
         8'd8:    id_word = TOTAL[15:0];
         8'd22:   id_word = ATF_ID_W22;
         8'd47:   id_word = ATF_ID_W47;
         8'd49:   id_word = ATF_ID_W49;
         8'd51:   id_word = ATF_ID_W51;
         8'd53:   id_word = ATF_ID_W53;
         8'd57:   id_word = TOTAL[15:0];
         8'd58:   id_word = TOTAL[31:16];
         8'd59:   id_word = ATF_ID_W59;
         8'd60:   id_word = TOTAL[15:0];
         8'd61:   id_word = TOTAL[31:16];
         8'd63:   id_word = ATF_ID_W63;
         8'd64:   id_word = ATF_ID_W64;
         8'd65,
         8'd66,
         8'd67,
         8'd68:   id_word = ATF_ID_W65_68;
         8'd80:   id_word = ATF_ID_W80;
         8'd88:   id_word = ATF_ID_W88;
         default: begin
            // Text fields hold blanks; all reserved words read zero.
            if ((w >= 8'd10 && w <= 8'd19) || (w >= 8'd23 && w <= 8'd46)) begin
               id_word = ATF_ID_TEXT;
            end else begin
               id_word = 16'h0000;
            end
         end
      endcase
   endfunction : id_word

   wire busy      = status[ATF_ST_BSY];
   wire cfg_vis   = !ide_mode;
   wire io_map    = cfg_opt[ATF_COR_IDX_HI:0] != ATF_MAP_MEM;
   wire wr_cmd    = wr && (addr == ATF_STATUS);
   wire wr_dc     = wr && (addr == ATF_ALTSTAT);
   wire rd_stat   = rd && (addr == ATF_STATUS);
   wire rd_data   = rd && (addr == ATF_DATA) && (state == ATF_IDENT);
   wire id_last   = byte_mode ? (byte_hi && id_idx == 8'hff) : (id_idx == 8'hff);
   wire srst_req  = (wr_dc && wdata[ATF_DC_SRST]) ||
                    (wr && addr == ATF_CFG_OPT && cfg_vis && wdata[ATF_COR_SRESET]);
   wire [15:0] id_cur = id_word(id_idx, ide_mode);
   // Byte access returns the low then the high half of each word.
   wire [15:0] data_out = byte_mode ? {8'h00, byte_hi ? id_cur[15:8] : id_cur[7:0]}
                                    : id_cur;
   wire [7:0]  prr_val = {6'h00, io_map & irq, 1'b0};

   assign irq      = irq_pend && !dev_ctl[ATF_DC_NIEN];
   assign lba      = drvhead[ATF_DH_LBA] ? {drvhead[3:0], cylhi, cyllo, secnum}
                                         : {drvhead[3:0], cylhi, cyllo, secnum};
   assign xfer_cnt = (seccnt == 8'h00) ? 9'd256 : {1'b0, seccnt};
   assign map_mode = atf_map_t'(cfg_opt[ATF_COR_IDX_HI:0]);

   always_ff @(posedge sys_clk) begin
      if (!rstn || srst_req) begin
         feature   <= 8'h00;
         seccnt    <= 8'h01;
         secnum    <= 8'h01;
         cyllo     <= 8'h00;
         cylhi     <= 8'h00;
         drvhead   <= 8'h00;
         status    <= ATF_STATUS_RST;
         err       <= ATF_DIAG_OK;
         irq_pend  <= 1'b0;
         state     <= ATF_IDLE;
         id_idx    <= 8'h00;
         byte_hi   <= 1'b0;
         cmd       <= 8'h00;
         cmd_stb   <= 1'b0;
         cfg_opt   <= 8'h00;
         cfg_stat  <= 8'h00;
         // Soft reset keeps device control so the host can release it.
         if (!rstn) begin
            dev_ctl   <= 8'h00;
            sock_copy <= 8'h00;
            byte_mode <= 1'b0;
         end else if (wr_dc) begin
            dev_ctl <= wdata[7:0];
         end
      end else begin
         cmd_stb <= wr_cmd && !busy;
         if (wr && !busy) begin
            case (addr)
               ATF_ERROR:     feature   <= wdata[7:0];
               ATF_SECCNT:    seccnt    <= wdata[7:0];
               ATF_SECNUM:    secnum    <= wdata[7:0];
               ATF_CYLLO:     cyllo     <= wdata[7:0];
               ATF_CYLHI:     cylhi     <= wdata[7:0];
               ATF_DRVHEAD:   drvhead   <= wdata[7:0];
               ATF_SOCK_COPY: if (cfg_vis) sock_copy <= wdata[7:0];
               ATF_CFG_OPT:   if (cfg_vis) cfg_opt <= {1'b0, wdata[6:0]};
               ATF_CFG_STAT:  if (cfg_vis) cfg_stat <= wdata[7:0];
               ATF_MODE:      byte_mode <= wdata[0];
               default:       ;
            endcase
         end
         if (wr_dc) begin
            dev_ctl <= wdata[7:0];
         end
         if (wr_cmd && !busy) begin
            cmd <= wdata[7:0];
            status[ATF_ST_ERR] <= 1'b0;
            case (wdata[7:0])
               ATF_CMD_IDENT: begin
                  state <= ATF_IDENT;
                  id_idx <= 8'h00;
                  byte_hi <= 1'b0;
                  status[ATF_ST_DRQ] <= 1'b1;
                  irq_pend <= 1'b1;
               end
               ATF_CMD_DIAG: begin
                  err <= ATF_DIAG_OK;
                  irq_pend <= 1'b1;
               end
               ATF_CMD_SENSE: begin
                  err <= 8'h00;
                  irq_pend <= 1'b1;
               end
               ATF_CMD_SETFT: begin
                  if (feature == ATF_FT_8BIT_ON) byte_mode <= 1'b1;
                  if (feature == ATF_FT_8BIT_OF) byte_mode <= 1'b0;
                  irq_pend <= 1'b1;
               end
               default: irq_pend <= 1'b1;
            endcase
         end else if (rd_stat) begin
            irq_pend <= 1'b0;
         end
         if (rd_data) begin
            if (byte_mode && !byte_hi) begin
               byte_hi <= 1'b1;
            end else begin
               byte_hi <= 1'b0;
               id_idx  <= id_idx + 8'h01;
            end
            if (id_last) begin
               state <= ATF_IDLE;
               status[ATF_ST_DRQ] <= 1'b0;
            end
         end
      end
   end

   // Read mux: one cycle latency; hidden registers read zero.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         rdata <= 16'h0000;
      end else if (rd) begin
         case (addr)
            ATF_DATA:      rdata <= (state == ATF_IDENT) ? data_out : data_buf;
            ATF_ERROR:     rdata <= busy ? 16'h0000 : {8'h00, err};
            ATF_SECCNT:    rdata <= {8'h00, seccnt};
            ATF_SECNUM:    rdata <= {8'h00, secnum};
            ATF_CYLLO:     rdata <= {8'h00, cyllo};
            ATF_CYLHI:     rdata <= {8'h00, cylhi};
            ATF_DRVHEAD:   rdata <= {8'h00, drvhead};
            ATF_STATUS,
            ATF_ALTSTAT:   rdata <= {8'h00, status};
            ATF_DRVADDR:   rdata <= {8'h00, 2'b01, ~drvhead[3:0], 2'b10};
            ATF_CFG_OPT:   rdata <= cfg_vis ? {8'h00, cfg_opt} : 16'h0000;
            ATF_CFG_STAT:  rdata <= cfg_vis ? {8'h00, cfg_stat} : 16'h0000;
            ATF_PIN_REPL:  rdata <= cfg_vis ? {8'h00, prr_val} : 16'h0000;
            ATF_SOCK_COPY: rdata <= cfg_vis ? {8'h00, sock_copy} : 16'h0000;
            ATF_MODE:      rdata <= {15'h0000, byte_mode};
            default:       rdata <= 16'h0000;
         endcase
      end else begin
         rdata <= 16'h0000;
      end
   end

   // Data register holds the last word the host wrote outside a transfer.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         data_buf <= 16'h0000;
      end else if (wr && addr == ATF_DATA) begin
         data_buf <= byte_mode ? {data_buf[15:8], wdata[7:0]} : wdata;
      end
   end

   // Soft reset acts inside the block; the pulse lets the media side abort its own work too.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         soft_rst <= 1'b0;
      end else begin
         soft_rst <= srst_req;
      end
   end

   logic unused_ok;
   assign unused_ok = ^{lba[0], ATF_ID_WORDS[0]};

   // Steps of an identify transfer as the host sees them.
   sequence id_word_rd_s;
      rd_data && !byte_mode;
   endsequence
   sequence id_byte_lo_s;
      rd_data && byte_mode && !byte_hi;
   endsequence
   sequence id_end_s;
      rd_data && id_last;
   endsequence

   data_word_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      id_word_rd_s |=> rdata == $past(id_cur))
      else $error("identify word not delivered");
   byte_low_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      id_byte_lo_s |=> byte_hi && rdata == {8'h00, $past(id_cur[7:0])})
      else $error("low byte not delivered first");
   drq_end_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      id_end_s |=> !status[ATF_ST_DRQ] && state == ATF_IDLE)
      else $error("transfer did not end after last word");
   cmd_pulse_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      wr_cmd && !busy |=> cmd_stb && cmd == $past(wdata[7:0]))
      else $error("command not accepted");
   srst_pulse_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      srst_req |=> soft_rst && secnum == 8'h01 && status == ATF_STATUS_RST)
      else $error("soft reset not applied");
   alt_keep_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      rd && addr == ATF_ALTSTAT |=> irq_pend == $past(irq_pend))
      else $error("alternate status read changed interrupt");
   sock_lock_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      wr && ide_mode && addr == ATF_SOCK_COPY |=> $stable(sock_copy))
      else $error("socket register written in ide mode");
   setft_on_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      wr_cmd && !busy && wdata[7:0] == ATF_CMD_SETFT && feature == ATF_FT_8BIT_ON
      |=> byte_mode)
      else $error("set features did not select bytes");
   lba_build_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      drvhead[ATF_DH_LBA] |-> lba == {drvhead[3:0], cylhi, cyllo, secnum})
      else $error("block address wrong");
   count_pass_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      seccnt != 8'h00 |-> xfer_cnt == {1'b0, seccnt})
      else $error("sector count not passed");

   word0_fix_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      id_word(8'd0, 1'b1) == ATF_ID_W0_FIX && id_word(8'd0, 1'b0) == ATF_ID_W0_REM)
      else $error("identify word 0 wrong");
   cap_order_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      {id_word(8'd7, ide_mode), id_word(8'd8, ide_mode)} ==
      {id_word(8'd58, ide_mode), id_word(8'd57, ide_mode)})
      else $error("capacity word order wrong");
   timing_words_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      id_word(8'd65, 1'b0) == 16'h0078 && id_word(8'd68, 1'b0) == 16'h0078)
      else $error("timing words wrong");
   udma_word_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      id_word(8'd88, 1'b0) == 16'h003f && id_word(8'd53, 1'b0) == 16'h0007)
      else $error("capability words wrong");
   stat_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      rd_stat && !wr_cmd && !srst_req |=> !irq_pend)
      else $error("status read kept interrupt");
   cfg_hide_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      rd && ide_mode && addr == ATF_CFG_OPT |=> rdata == 16'h0000)
      else $error("config visible in ide mode");
   zero_count_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      seccnt == 8'h00 |-> xfer_cnt == 9'd256)
      else $error("zero count not 256");
   nien_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
      dev_ctl[ATF_DC_NIEN] |-> !irq)
      else $error("interrupt not gated");
endmodule : atf_regs

/* File: tb/atf_host.sv */
// Host bus master model driving the card's task file register port.
`timescale 1ns/100ps
module atf_host (
   input  wire logic        sys_clk, // card clock
   input  wire logic [15:0] rdata,   // read data from the card
   output logic      [4:0]  addr,    // register address
   output logic      [15:0] wdata,   // write data
   output logic             wr,      // write strobe
   output logic             rd       // read strobe
);
   initial begin
      addr = 5'h00;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
   end

   // Released lines show the inverse of their last value, so a stale value cannot pass.
   task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge sys_clk);
      wr    <= 1'b0;
      addr  <= ~a;
      wdata <= ~d;
   endtask : wr_reg

   // Read data stand only in the cycle after the strobe, so they are taken there.
   task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge sys_clk);
      rd   <= 1'b0;
      addr <= ~a;
      #1;
      d = rdata;
   endtask : rd_reg
endmodule : atf_host

/* File: tb/tb_atf_regs.sv */
// Self-checking testbench for the task file and identify register block.
`timescale 1ns/100ps
module tb_atf_regs;
   import atf_pkg::*;
   localparam logic [15:0] CYLS  = 16'h0123;
   localparam logic [15:0] HEADS = 16'h0008;
   localparam logic [15:0] SPT   = 16'h003f;
   localparam logic [31:0] TOTAL = 32'h0004_7a58;
   logic        sys_clk, rstn, ide_mode, wr, rd, irq, cmd_stb, soft_rst;
   logic [4:0]  addr;
   logic [15:0] wdata, rdata, v;
   logic [7:0]  cmd;
   logic [27:0] lba;
   logic [8:0]  xfer_cnt;
   atf_map_t    map_mode;
   int          miscompares, compares, cyc;

   atf_regs #(.CYLS(CYLS), .HEADS(HEADS), .SPT(SPT), .TOTAL(TOTAL)) i_dut (
      .sys_clk(sys_clk), .rstn(rstn), .ide_mode(ide_mode), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .cmd(cmd), .cmd_stb(cmd_stb), .lba(lba),
      .xfer_cnt(xfer_cnt), .soft_rst(soft_rst), .map_mode(map_mode));
   atf_host i_host (.sys_clk(sys_clk), .rdata(rdata), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd));

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic finish_test();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : finish_test

   // Card-dependent words with no fixed figure (retired words, LBA total) are skipped.
   function automatic logic [16:0] id_exp(input int w, input logic [15:0] w0);
      case (w)
         0: return {1'b1, w0};
         1, 54: return {1'b1, CYLS};
         3, 55: return {1'b1, HEADS};
         6, 56: return {1'b1, SPT};
         7: return {1'b1, TOTAL[31:16]};
         8, 57: return {1'b1, TOTAL[15:0]};
         58: return {1'b1, TOTAL[31:16]};
         22: return {1'b1, ATF_ID_W22};
         47: return {1'b1, ATF_ID_W47};
         49: return {1'b1, ATF_ID_W49};
         51: return {1'b1, ATF_ID_W51};
         53: return {1'b1, ATF_ID_W53};
         59: return {1'b1, ATF_ID_W59};
         63: return {1'b1, ATF_ID_W63};
         64: return {1'b1, ATF_ID_W64};
         65, 66, 67, 68: return {1'b1, ATF_ID_W65_68};
         80: return {1'b1, ATF_ID_W80};
         88: return {1'b1, ATF_ID_W88};
         4, 5, 20, 21, 60, 61: return 17'h00000;
         default: return {1'b1, ((w >= 10 && w <= 19) || (w >= 23 && w <= 46)) ?
                          ATF_ID_TEXT : 16'h0000};
      endcase
   endfunction : id_exp

   task automatic cmd_wr(input logic [7:0] c);
      i_host.wr_reg(ATF_STATUS, {8'h00, c});
      #1;
      chk("cmd strobe", 1'b1, cmd_stb);
      repeat (2) @(posedge sys_clk);
      #1;
      chk("cmd", c, cmd);
      chk("cmd strobe end", 1'b0, cmd_stb);
   endtask : cmd_wr

   task automatic identify(input logic [15:0] w0);
      logic [16:0] e;
      cmd_wr(ATF_CMD_IDENT);
      chk("irq after command", 1'b1, irq);
      i_host.rd_reg(ATF_ALTSTAT, v);
      chk("alt status drq", 1'b1, v[ATF_ST_DRQ]);
      chk("irq after alt read", 1'b1, irq);
      for (int w = 0; w < ATF_ID_WORDS; w++) begin
         i_host.rd_reg(ATF_DATA, v);
         e = id_exp(w, w0);
         if (e[16]) begin
            chk($sformatf("identify word %0d", w), e[15:0], v);
         end
      end
      i_host.rd_reg(ATF_STATUS, v);
      chk("status after block", ATF_STATUS_RST, v);
      @(posedge sys_clk);
      #1;
      chk("irq after status read", 1'b0, irq);
   endtask : identify

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc > 20000) begin
         miscompares++;
         finish_test();
      end
   end

   initial begin
      rstn = 1'b0;
      ide_mode = 1'b0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      i_host.rd_reg(ATF_STATUS, v);
      chk("status reset", ATF_STATUS_RST, v);
      i_host.rd_reg(ATF_ERROR, v);
      chk("error reset", 16'h0001, v);
      identify(ATF_ID_W0_REM);
      // Parameters go in before the opcode.
      i_host.wr_reg(ATF_SECNUM, 16'h0012);
      i_host.wr_reg(ATF_CYLLO, 16'h0034);
      i_host.wr_reg(ATF_CYLHI, 16'h0056);
      i_host.wr_reg(ATF_DRVHEAD, 16'h004a);
      i_host.wr_reg(ATF_SECCNT, 16'h0000);
      #1;
      chk("lba", 28'ha563412, lba);
      chk("count zero", 9'h100, xfer_cnt);
      i_host.wr_reg(ATF_SECCNT, 16'h00ff);
      #1;
      chk("count max", 9'h0ff, xfer_cnt);
      cmd_wr(ATF_CMD_DIAG);
      i_host.rd_reg(ATF_ERROR, v);
      chk("diag code", ATF_DIAG_OK, v);
      cmd_wr(ATF_CMD_SENSE);
      i_host.rd_reg(ATF_ERROR, v);
      chk("sense code", 16'h0000, v);
      chk("irq pending", 1'b1, irq);
      i_host.wr_reg(ATF_ALTSTAT, 16'h0001 << ATF_DC_NIEN);
      #1;
      chk("irq gated", 1'b0, irq);
      i_host.wr_reg(ATF_ALTSTAT, 16'h0000);
      #1;
      chk("irq ungated", 1'b1, irq);
      // Socket register goes first, then each of the four mappings.
      i_host.wr_reg(ATF_SOCK_COPY, 16'h005a);
      i_host.rd_reg(ATF_SOCK_COPY, v);
      chk("socket copy", 16'h005a, v[7:0]);
      for (int m = 0; m < 4; m++) begin
         i_host.wr_reg(ATF_CFG_OPT, m[15:0]);
         #1;
         chk("map mode", m[1:0], map_mode);
         i_host.rd_reg(ATF_PIN_REPL, v);
         chk("pin repl irq", (m != 0), v[ATF_PRR_IREQ]);
      end
      i_host.wr_reg(ATF_CFG_OPT, 16'h0001 << ATF_COR_SRESET);
      i_host.rd_reg(ATF_SECNUM, v);
      chk("secnum after cfg reset", 16'h0001, v);
      i_host.wr_reg(ATF_MODE, 16'h0001);
      cmd_wr(ATF_CMD_IDENT);
      i_host.rd_reg(ATF_DATA, v);
      chk("byte low", ATF_ID_W0_REM[7:0], v[7:0]);
      i_host.rd_reg(ATF_DATA, v);
      chk("byte high", ATF_ID_W0_REM[15:8], v[7:0]);
      i_host.wr_reg(ATF_ALTSTAT, 16'h0001 << ATF_DC_SRST);
      #1;
      chk("soft reset pulse", 1'b1, soft_rst);
      i_host.wr_reg(ATF_ALTSTAT, 16'h0000);
      i_host.rd_reg(ATF_STATUS, v);
      chk("status after soft reset", ATF_STATUS_RST, v);
      i_host.wr_reg(ATF_MODE, 16'h0000);
      i_host.wr_reg(ATF_ERROR, {8'h00, ATF_FT_8BIT_ON});
      cmd_wr(ATF_CMD_SETFT);
      i_host.rd_reg(ATF_MODE, v);
      chk("set features 8-bit", 16'h0001, v);
      i_host.wr_reg(ATF_ERROR, {8'h00, ATF_FT_8BIT_OF});
      cmd_wr(ATF_CMD_SETFT);
      i_host.rd_reg(ATF_MODE, v);
      chk("set features 16-bit", 16'h0000, v);
      ide_mode <= 1'b1;
      i_host.wr_reg(ATF_SOCK_COPY, 16'h00a5);
      i_host.rd_reg(ATF_SOCK_COPY, v);
      chk("cfg hidden", 16'h0000, v);
      identify(ATF_ID_W0_FIX);
      finish_test();
   end
endmodule : tb_atf_regs
